// File: core/pis_pkg.sv
// Operation
// - summary register at command 00h, read only; writes leave it unchanged
// - summary bits active high; set means event class seen since last clear
// - clear-on-read of an event register clears its summary bits; reset bit 7 clears all
// - interrupt active when a summary bit, its mask bit and global enable are set
// - bit 7 is thermal shutdown or digital or power supply undervoltage
// - bit 6 is OR of the four port start fault flags
// - bit 5 is OR of four overcurrent cutoff and four current limit flags
// - bit 4 is OR of the four port classification cycle flags
// - bit 3 is OR of the four port detection cycle flags
// - bit 2 is OR of the four port disconnect flags
// - bit 1 is OR of the four port power-good change flags
// - bit 0 is OR of the four port power-enable change flags
// - enable mask at command 01h, read/write, bit-aligned with summary
// - mask bit written 1 lets its summary event drive the interrupt
// - mask bit written 0 blocks its summary event from the interrupt
// - summary bits follow events regardless of mask; mask gates only interrupt
// - global interrupt enable must also be set for any interrupt
// - each event register has a plain read code and a clear-on-read code
// - clear-on-read of the interrupting event register releases the interrupt
package pis_pkg;

    // ********************************
    // command codes
    // ********************************
    localparam logic [7:0] CMD_SUMMARY     = 8'h00;
    localparam logic [7:0] CMD_ENABLE_MASK = 8'h01;
    localparam logic [7:0] CMD_POWER_COR   = 8'h03;
    localparam logic [7:0] CMD_DETECT_COR  = 8'h05;
    localparam logic [7:0] CMD_FAULT_COR   = 8'h07;
    localparam logic [7:0] CMD_START_COR   = 8'h09;
    localparam logic [7:0] CMD_SUPPLY_COR  = 8'h0b;

    // ********************************
    // summary bit positions
    // ********************************
    localparam int BIT_SUPPLY_FAULT  = 7;
    localparam int BIT_START_FAULT   = 6;
    localparam int BIT_CURRENT_FAULT = 5;
    localparam int BIT_CLASS_CYCLE   = 4;
    localparam int BIT_DETECT_CYCLE  = 3;
    localparam int BIT_DISCONNECT    = 2;
    localparam int BIT_POWER_GOOD    = 1;
    localparam int BIT_POWER_ENABLE  = 0;

    // ********************************
    // event register clear strobes
    // ********************************
    localparam int CLR_POWER  = 0;
    localparam int CLR_DETECT = 1;
    localparam int CLR_FAULT  = 2;
    localparam int CLR_START  = 3;
    localparam int CLR_SUPPLY = 4;
    localparam int CLR_COUNT  = 5;

    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] SUMMARY_RESET    = 8'h80;
    localparam logic [7:0] MASK_RESET_FIXED = 8'h80;
    localparam logic [7:0] MASK_RESET_MODE  = 8'h64;

    // summary bits covered by each clear-on-read code
    function automatic logic [7:0] pis_clear_cover(input logic [CLR_COUNT-1:0] clr);
        logic [7:0] c;
        c = 8'h00;
        c[BIT_POWER_GOOD]    = clr[CLR_POWER];
        c[BIT_POWER_ENABLE]  = clr[CLR_POWER];
        c[BIT_CLASS_CYCLE]   = clr[CLR_DETECT];
        c[BIT_DETECT_CYCLE]  = clr[CLR_DETECT];
        c[BIT_DISCONNECT]    = clr[CLR_FAULT];
        c[BIT_CURRENT_FAULT] = clr[CLR_FAULT] | clr[CLR_START];
        c[BIT_START_FAULT]   = clr[CLR_START];
        c[BIT_SUPPLY_FAULT]  = clr[CLR_SUPPLY];
        return c;
    endfunction : pis_clear_cover

endpackage : pis_pkg

// File: core/pis_flag_merge.sv
`timescale 1ns/1ps
module pis_flag_merge (
    input  wire logic [3:0] port_start_fault_flag,
    input  wire logic [3:0] port_overcurrent_cutoff_flag,
    input  wire logic [3:0] port_current_limit_flag,
    input  wire logic [3:0] port_class_cycle_flag,
    input  wire logic [3:0] port_detect_cycle_flag,
    input  wire logic [3:0] port_disconnect_flag,
    input  wire logic [3:0] port_power_good_change_flag,
    input  wire logic [3:0] port_power_enable_change_flag,
    input  wire logic       thermal_shutdown_flag,
    input  wire logic       digital_supply_undervolt_flag,
    input  wire logic       power_supply_undervolt_flag,
    output logic      [7:0] merged
);

    assign merged[pis_pkg::BIT_SUPPLY_FAULT]  = thermal_shutdown_flag
                                              | digital_supply_undervolt_flag
                                              | power_supply_undervolt_flag;
    assign merged[pis_pkg::BIT_START_FAULT]   = |port_start_fault_flag;
    assign merged[pis_pkg::BIT_CURRENT_FAULT] = |{port_overcurrent_cutoff_flag,
                                                  port_current_limit_flag};
    assign merged[pis_pkg::BIT_CLASS_CYCLE]   = |port_class_cycle_flag;
    assign merged[pis_pkg::BIT_DETECT_CYCLE]  = |port_detect_cycle_flag;
    assign merged[pis_pkg::BIT_DISCONNECT]    = |port_disconnect_flag;
    assign merged[pis_pkg::BIT_POWER_GOOD]    = |port_power_good_change_flag;
    assign merged[pis_pkg::BIT_POWER_ENABLE]  = |port_power_enable_change_flag;

endmodule : pis_flag_merge

// File: core/pis_interrupt_summary.sv
`timescale 1ns/1ps
module pis_interrupt_summary #(
    parameter logic MODE_ENABLE_DEFAULT = 1'b1
) (
    input  wire logic                         clock,
    input  wire logic                         resetn,
    input  wire logic [7:0]                   cmd_code,
    input  wire logic                         cmd_rd,
    input  wire logic                         cmd_wr,
    input  wire logic [7:0]                   cmd_wdata,
    output logic      [7:0]                   cmd_rdata,
    output logic                              cmd_rvalid,
    output logic                              cmd_hit,
    input  wire logic                         global_irq_en,
    input  wire logic                         clear_all_req,
    input  wire logic [3:0]                   port_start_fault_flag,
    input  wire logic [3:0]                   port_overcurrent_cutoff_flag,
    input  wire logic [3:0]                   port_current_limit_flag,
    input  wire logic [3:0]                   port_class_cycle_flag,
    input  wire logic [3:0]                   port_detect_cycle_flag,
    input  wire logic [3:0]                   port_disconnect_flag,
    input  wire logic [3:0]                   port_power_good_change_flag,
    input  wire logic [3:0]                   port_power_enable_change_flag,
    input  wire logic                         thermal_shutdown_flag,
    input  wire logic                         digital_supply_undervolt_flag,
    input  wire logic                         power_supply_undervolt_flag,
    output logic      [pis_pkg::CLR_COUNT-1:0] event_clear,
    output logic                              event_clear_all,
    output logic      [7:0]                   interrupt_summary,
    output logic      [7:0]                   interrupt_enable_mask,
    output logic                              int_n
);

    // ********************************
    // reset value of the mask
    // ********************************
    localparam logic [7:0] MASK_RESET = pis_pkg::MASK_RESET_FIXED
        | (MODE_ENABLE_DEFAULT ? pis_pkg::MASK_RESET_MODE : 8'h00);

    logic [7:0]                    merged;
    logic [7:0]                    summary_r;
    logic [7:0]                    summary_nxt;
    logic [7:0]                    mask_r;
    logic [7:0]                    mask_nxt;
    logic                          int_n_r;
    logic                          int_n_nxt;
    logic [7:0]                    rdata_r;
    logic                          rvalid_r;
    logic                          hit_r;
    logic [pis_pkg::CLR_COUNT-1:0] clear_r;
    logic                          clear_all_r;

    // ********************************
    // event flag merge
    // ********************************
    pis_flag_merge u_merge (
        .port_start_fault_flag         (port_start_fault_flag),
        .port_overcurrent_cutoff_flag  (port_overcurrent_cutoff_flag),
        .port_current_limit_flag       (port_current_limit_flag),
        .port_class_cycle_flag         (port_class_cycle_flag),
        .port_detect_cycle_flag        (port_detect_cycle_flag),
        .port_disconnect_flag          (port_disconnect_flag),
        .port_power_good_change_flag   (port_power_good_change_flag),
        .port_power_enable_change_flag (port_power_enable_change_flag),
        .thermal_shutdown_flag         (thermal_shutdown_flag),
        .digital_supply_undervolt_flag (digital_supply_undervolt_flag),
        .power_supply_undervolt_flag   (power_supply_undervolt_flag),
        .merged                        (merged)
    );

    // ********************************
    // command decode
    // ********************************
    wire sel_summary = cmd_code == pis_pkg::CMD_SUMMARY;
    wire sel_mask    = cmd_code == pis_pkg::CMD_ENABLE_MASK;
    wire sel_power   = cmd_code == pis_pkg::CMD_POWER_COR;
    wire sel_detect  = cmd_code == pis_pkg::CMD_DETECT_COR;
    wire sel_fault   = cmd_code == pis_pkg::CMD_FAULT_COR;
    wire sel_start   = cmd_code == pis_pkg::CMD_START_COR;
    wire sel_supply  = cmd_code == pis_pkg::CMD_SUPPLY_COR;
    wire own_code    = sel_summary | sel_mask;

    // clear-on-read strobes to the event registers
    wire [pis_pkg::CLR_COUNT-1:0] clear_nxt =
        {5{cmd_rd}} & {sel_supply, sel_start, sel_fault, sel_detect, sel_power};

    // summary mirrors the event registers; clears act by emptying them
    assign summary_nxt = merged;

    // writes to the summary code are ignored
    assign mask_nxt = (cmd_wr && sel_mask) ? cmd_wdata : mask_r;

    // masked, globally gated, from the live event flags
    assign int_n_nxt = ~(global_irq_en && |(merged & mask_r));

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            summary_r   <= pis_pkg::SUMMARY_RESET;
            mask_r      <= MASK_RESET;
            int_n_r     <= 1'b1;
        end else begin
            summary_r   <= summary_nxt;
            mask_r      <= mask_nxt;
            int_n_r     <= int_n_nxt;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_r     <= 8'h00;
            rvalid_r    <= 1'b0;
            hit_r       <= 1'b0;
            clear_r     <= '0;
            clear_all_r <= 1'b0;
        end else begin
            rvalid_r    <= cmd_rd;
            hit_r       <= (cmd_rd || cmd_wr) && own_code;
            clear_r     <= clear_nxt;
            clear_all_r <= clear_all_req;
            if (cmd_rd) begin
                rdata_r <= sel_summary ? summary_r :
                           sel_mask    ? mask_r    : 8'h00;
            end
        end
    end

    assign cmd_rdata             = rdata_r;
    assign cmd_rvalid            = rvalid_r;
    assign cmd_hit               = hit_r;
    assign event_clear           = clear_r;
    assign event_clear_all       = clear_all_r;
    assign interrupt_summary     = summary_r;
    assign interrupt_enable_mask = mask_r;
    assign int_n                 = int_n_r;

endmodule : pis_interrupt_summary

// File: test/pis_summary_checker.sv
`timescale 1ns/1ps
module pis_summary_checker (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       cmd_rd,
    input wire logic       cmd_wr,
    input wire logic       cmd_rvalid,
    input wire logic       cmd_hit,
    input wire logic       global_irq_en,
    input wire logic       clear_all_req,
    input wire logic       event_clear_all,
    input wire logic       int_n,
    input wire logic       thermal_shutdown_flag,
    input wire logic       digital_supply_undervolt_flag,
    input wire logic       power_supply_undervolt_flag,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic [7:0] interrupt_summary,
    input wire logic [7:0] interrupt_enable_mask,
    input wire logic [3:0] port_start_fault_flag,
    input wire logic [4:0] event_clear
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    supply_bit_a: assert property (interrupt_summary[7] == $past(thermal_shutdown_flag
        | digital_supply_undervolt_flag | power_supply_undervolt_flag)) else $error("supply bit wrong");
    start_bit_a: assert property (interrupt_summary[6] == $past(|port_start_fault_flag))
        else $error("start bit wrong");
    irq_out_a: assert property ($past(resetn) |-> int_n == !($past(global_irq_en)
        && |(interrupt_summary & $past(interrupt_enable_mask)))) else $error("irq output wrong");
    mask_write_a: assert property (cmd_wr && cmd_code == pis_pkg::CMD_ENABLE_MASK
        |=> interrupt_enable_mask == $past(cmd_wdata)) else $error("mask not written");
    mask_hold_a: assert property (!(cmd_wr && cmd_code == pis_pkg::CMD_ENABLE_MASK)
        |=> $stable(interrupt_enable_mask)) else $error("mask changed unasked");
    read_back_a: assert property (cmd_rd && cmd_code == pis_pkg::CMD_SUMMARY
        |=> cmd_rvalid && cmd_rdata == $past(interrupt_summary)) else $error("summary read wrong");
    clear_cor_a: assert property (cmd_rd && cmd_code == pis_pkg::CMD_FAULT_COR
        |=> event_clear == 5'h04) else $error("clear strobe wrong");
    clear_all_a: assert property (clear_all_req |=> event_clear_all)
        else $error("clear all missing");
    own_hit_a: assert property ((cmd_rd || cmd_wr) && (cmd_code == pis_pkg::CMD_SUMMARY
        || cmd_code == pis_pkg::CMD_ENABLE_MASK) |=> cmd_hit) else $error("own code not flagged");
endmodule : pis_summary_checker
bind pis_interrupt_summary pis_summary_checker chk (.*);

// File: test/pis_event_model.sv
`timescale 1ns/1ps
module pis_event_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [34:0] set_ev,
    input  wire logic [4:0]  event_clear,
    input  wire logic        event_clear_all,
    output logic      [34:0] ev_r
);
    logic [34:0] clr_m;
    assign clr_m = {35{event_clear_all}} | {{3{event_clear[4]}}, {8{event_clear[3]}},
        {8{event_clear[2]}}, {8{event_clear[1]}}, {8{event_clear[0]}}};
    // supply undervolt flags come up set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) ev_r <= 35'h3_0000_0000;
        else ev_r <= (ev_r & ~clr_m) | set_ev;
    end
endmodule : pis_event_model

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [34:0] set; logic [7:0] sum; logic [7:0] code; logic [4:0] clr;} pis_row_s;
    logic        clock, resetn, cmd_rd, cmd_wr, global_irq_en, clear_all_req;
    logic [7:0]  cmd_code, cmd_wdata;
    logic [34:0] set_ev;
    wire  [34:0] ev;
    wire  [7:0]  cmd_rdata, interrupt_summary, interrupt_enable_mask;
    wire  [4:0]  event_clear;
    wire         cmd_rvalid, cmd_hit, event_clear_all, int_n;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    pis_row_s    rows [9] = '{'{35'h1, 8'h01, 8'h03, 5'h01}, '{35'h80, 8'h02, 8'h03, 5'h01},
        '{35'h200, 8'h08, 8'h05, 5'h02}, '{35'h4000, 8'h10, 8'h05, 5'h02},
        '{35'h1_0000, 8'h20, 8'h07, 5'h04}, '{35'h80_0000, 8'h04, 8'h07, 5'h04},
        '{35'h200_0000, 8'h40, 8'h09, 5'h08}, '{35'h4000_0000, 8'h20, 8'h09, 5'h08},
        '{35'h4_0000_0000, 8'h80, 8'h0b, 5'h10}};
    pis_event_model pm (.clock, .resetn, .set_ev, .event_clear, .event_clear_all, .ev_r(ev));
    pis_interrupt_summary dut (.clock, .resetn, .cmd_code, .cmd_rd, .cmd_wr, .cmd_wdata,
        .cmd_rdata, .cmd_rvalid, .cmd_hit, .global_irq_en, .clear_all_req,
        .port_start_fault_flag(ev[27:24]), .port_overcurrent_cutoff_flag(ev[19:16]),
        .port_current_limit_flag(ev[31:28]), .port_class_cycle_flag(ev[15:12]),
        .port_detect_cycle_flag(ev[11:8]), .port_disconnect_flag(ev[23:20]),
        .port_power_good_change_flag(ev[7:4]), .port_power_enable_change_flag(ev[3:0]),
        .thermal_shutdown_flag(ev[34]), .digital_supply_undervolt_flag(ev[33]),
        .power_supply_undervolt_flag(ev[32]), .event_clear, .event_clear_all,
        .interrupt_summary, .interrupt_enable_mask, .int_n);
    task automatic report_and_stop;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step
    task automatic acc(input logic rd, input logic [7:0] code, input logic [7:0] wd);
        cmd_rd = rd;
        cmd_wr = !rd;
        cmd_code = code;
        cmd_wdata = wd;
        step(1);
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
    endtask : acc
    task automatic pulse_ev(input logic [34:0] v);
        set_ev = v;
        step(1);
        set_ev = '0;
        step(1);
    endtask : pulse_ev
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 500) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        {resetn, cmd_rd, cmd_wr, clear_all_req, cmd_code, cmd_wdata, set_ev} = '0;
        global_irq_en = 1'b1;
        step(8);
        chk(interrupt_summary, pis_pkg::SUMMARY_RESET);
        chk(interrupt_enable_mask, pis_pkg::MASK_RESET_FIXED | pis_pkg::MASK_RESET_MODE);
        chk({7'h0, int_n}, 8'h01);
        resetn = 1'b1;
        step(2);
        chk(interrupt_summary, 8'h80);
        chk({7'h0, int_n}, 8'h00);
        acc(1'b0, pis_pkg::CMD_SUMMARY, 8'h00);
        acc(1'b1, pis_pkg::CMD_SUMMARY, 8'h00);
        chk(cmd_rdata, 8'h80);
        chk({7'h0, cmd_hit}, 8'h01);
        acc(1'b0, pis_pkg::CMD_ENABLE_MASK, 8'hfe);
        pulse_ev(35'h1);
        chk(interrupt_summary, 8'h81);
        acc(1'b1, pis_pkg::CMD_SUPPLY_COR, 8'h00);
        chk({3'h0, event_clear}, 8'h10);
        step(2);
        chk(interrupt_summary, 8'h01);
        chk({7'h0, int_n}, 8'h01);
        acc(1'b0, pis_pkg::CMD_ENABLE_MASK, 8'h01);
        step(1);
        chk({7'h0, int_n}, 8'h00);
        acc(1'b1, pis_pkg::CMD_ENABLE_MASK, 8'h00);
        chk(cmd_rdata, 8'h01);
        global_irq_en = 1'b0;
        step(1);
        chk({7'h0, int_n}, 8'h01);
        global_irq_en = 1'b1;
        clear_all_req = 1'b1;
        step(1);
        clear_all_req = 1'b0;
        chk({7'h0, event_clear_all}, 8'h01);
        step(2);
        chk(interrupt_summary, 8'h00);
        acc(1'b0, pis_pkg::CMD_ENABLE_MASK, 8'hff);
        for (int i = 0; i < 9; i++) begin
            pulse_ev(rows[i].set);
            chk(interrupt_summary, rows[i].sum);
            chk({7'h0, int_n}, 8'h00);
            acc(1'b1, rows[i].code, 8'h00);
            chk({3'h0, event_clear}, {3'h0, rows[i].clr});
            chk({7'h0, cmd_hit}, 8'h00);
            step(2);
            chk({interrupt_summary[7:1], int_n}, 8'h01);
            chk(interrupt_summary, 8'h00);
        end
        // mid-run reset
        resetn = 1'b0;
        step(1);
        chk(interrupt_enable_mask, pis_pkg::MASK_RESET_FIXED | pis_pkg::MASK_RESET_MODE);
        chk(interrupt_summary, pis_pkg::SUMMARY_RESET);
        chk({7'h0, int_n}, 8'h01);
        resetn = 1'b1;
        step(2);
        chk(interrupt_summary, pis_pkg::SUMMARY_RESET);
        chk({7'h0, int_n}, 8'h00);
        report_and_stop();
    end
endmodule : tb
